//--- design/lce_accumulator.sv
// Line-cycle energy accumulator with AXI4-Lite register access
// Functional notes
// - Mode register bit 7 set enables half-cycle synchronized accumulation.
// - Periods start and end on voltage zero crossings, whole half cycles.
// - Active power is summed into the cycle energy total at 14h.
// - Half cycles per period come from a 14-bit count, up to 16383.
// - Period completion sets the done flag, status bit 2.
// - Done flag with its enable drives the interrupt output low.
// - A new period starts right after each one while mode stays set.
// - Cycle energy total is 40-bit signed two's complement, may wrap.
// - Energy updates once every four master clock periods.
// - Pulse rate scales by (numerator+1)/(denominator+1), at most one pulse per undivided event.
// - 12-bit gain trim scales pulse rate, 0.0244 percent per LSB.
// - Zero-crossing output follows the voltage line.
// - Running energy total is signed, giving direction and magnitude.
// - One undivided event each time a 24-bit accumulator MSB rises.
// - Reset loads denominator 3Fh and numerator zero.
`default_nettype none
module lce_accumulator
   import lce_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    srst,
   // Register bus
   input  wire lce_axil_req_t           axil_req,
   output lce_axil_rsp_t                axil_rsp,
   // Signal chain inputs
   input  wire logic signed [PWR_W-1:0] active_power,
   input  wire logic                    volt_sign,
   // Pins
   output logic                         irq_n,
   output logic                         energy_pulse_out,
   output logic                         zero_cross_out
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SYNC = 3'h2,
      ST_ACC  = 3'h4
   } lce_lc_state_t;

   typedef struct packed {
      logic [1:0]          div;
      lce_lc_state_t       fsm;
      logic                mode;
      logic                ien;
      logic                done;
      logic [HCC_W-1:0]    hcc;
      logic [HCC_W-1:0]    hc;
      logic [DIV_W-1:0]    num;
      logic [DIV_W-1:0]    den;
      logic [GAIN_W-1:0]   gain;
      logic [ENERGY_W-1:0] sum;
      logic [ENERGY_W-1:0] total;
      logic [ENERGY_W-1:0] run;
      logic                irq_n;
      logic                aw_got;
      logic [ADDR_W-1:0]   awaddr;
      logic                w_got;
      logic [DATA_W-1:0]   wdata;
      logic [3:0]          wstrb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [DATA_W-1:0]   rdata;
      logic [1:0]          rresp;
   } lce_acc_state_t;

   lce_acc_state_t              s;
   lce_acc_state_t              next_s;
   logic                        upd;
   logic                        zc;
   logic signed [35:0]          gain_prod;
   logic signed [SCALED_W-1:0]  scaled;
   logic        [ENERGY_W-1:0]  scaled_ext;
   logic        [DATA_W-1:0]    wmerge;
   logic        [HCC_W:0]       hc_next;

   // ============================================================
   // Sub-blocks
   lce_zero_cross u_zc (
      .clk            (clk),
      .srst           (srst),
      .volt_sign      (volt_sign),
      .zc_pulse       (zc),
      .zero_cross_out (zero_cross_out)
   );

   lce_pulse_gen u_pg (
      .clk       (clk),
      .srst      (srst),
      .upd       (upd),
      .power     (scaled),
      .pulse_num (s.num),
      .pulse_den (s.den),
      .pulse     (energy_pulse_out)
   );

   // ============================================================
   // Update rate and gain trim
   assign upd = (s.div == 2'(UPD_DIV - 1));
   // Gain is a signed fraction of 1/4096 per LSB added to unity
   assign gain_prod  = active_power * $signed(s.gain);
   assign scaled     = SCALED_W'($signed(active_power))
                       + SCALED_W'(gain_prod >>> GAIN_SHIFT);
   assign scaled_ext = ENERGY_W'($signed(scaled));
   assign hc_next    = {1'b0, s.hc} + 15'h0001;

   // Byte lanes honour the write strobes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmerge[i*8 +: 8] = s.wstrb[i] ? s.wdata[i*8 +: 8] : 8'h00;
      end
   end

   // ============================================================
   // Next state
   always_comb begin
      next_s     = s;
      next_s.div = s.div + 2'h1;

      // Running total wraps freely; signed reads give direction
      if (upd) begin
         next_s.run = s.run + scaled_ext;
      end

      // Write channel: address and data taken in either order
      if (axil_req.awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = axil_req.awaddr;
      end
      if (axil_req.wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = axil_req.wdata;
         next_s.wstrb = axil_req.wstrb;
      end
      if (s.bvalid && axil_req.bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         case (s.awaddr)
            OFF_MODE: begin
               if (s.wstrb[0]) begin
                  next_s.mode = wmerge[MODE_CYC_BIT];
               end
            end
            OFF_IRQ_STAT: begin
               // Write one to clear, applied before the set below
               if (wmerge[IRQ_DONE_BIT]) begin
                  next_s.done = 1'b0;
               end
            end
            OFF_IRQ_EN: begin
               if (s.wstrb[0]) begin
                  next_s.ien = wmerge[IRQ_DONE_BIT];
               end
            end
            OFF_PULSE_NUM: begin
               next_s.num = (s.num & ~{s.wstrb[1], s.wstrb[1], s.wstrb[1], s.wstrb[1],
                             {8{s.wstrb[0]}}}) | wmerge[DIV_W-1:0];
            end
            OFF_PULSE_DEN: begin
               next_s.den = (s.den & ~{s.wstrb[1], s.wstrb[1], s.wstrb[1], s.wstrb[1],
                             {8{s.wstrb[0]}}}) | wmerge[DIV_W-1:0];
            end
            OFF_CYCLE: begin
               next_s.hcc = (s.hcc & ~{{6{s.wstrb[1]}}, {8{s.wstrb[0]}}})
                            | wmerge[HCC_W-1:0];
            end
            OFF_GAIN: begin
               next_s.gain = (s.gain & ~{{4{s.wstrb[1]}}, {8{s.wstrb[0]}}})
                             | wmerge[GAIN_W-1:0];
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready  = !next_s.w_got && !next_s.bvalid;

      // Read channel
      if (s.rvalid && axil_req.rready) begin
         next_s.rvalid = 1'b0;
      end
      if (axil_req.arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = 32'h0000_0000;
         case (axil_req.araddr)
            OFF_MODE: begin
               next_s.rdata[MODE_CYC_BIT] = s.mode;
            end
            OFF_IRQ_STAT: begin
               next_s.rdata[IRQ_DONE_BIT] = s.done;
            end
            OFF_IRQ_EN: begin
               next_s.rdata[IRQ_DONE_BIT] = s.ien;
            end
            OFF_PULSE_NUM: begin
               next_s.rdata[DIV_W-1:0] = s.num;
            end
            OFF_PULSE_DEN: begin
               next_s.rdata[DIV_W-1:0] = s.den;
            end
            OFF_CYCLE: begin
               next_s.rdata = s.total[DATA_W-1:0];
            end
            OFF_CYC_HI: begin
               next_s.rdata = DATA_W'($signed(s.total[ENERGY_W-1:DATA_W]));
            end
            OFF_GAIN: begin
               next_s.rdata[GAIN_W-1:0] = s.gain;
            end
            OFF_RUN_LO: begin
               next_s.rdata = s.run[DATA_W-1:0];
            end
            OFF_RUN_HI: begin
               next_s.rdata = DATA_W'($signed(s.run[ENERGY_W-1:DATA_W]));
            end
            OFF_HCC_RD: begin
               next_s.rdata[HCC_W-1:0] = s.hcc;
            end
            default: begin
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
      next_s.arready = !next_s.rvalid;

      // ==========================================================
      // Line-cycle sequencer
      case (s.fsm)
         ST_IDLE: begin
            if (s.mode) begin
               next_s.fsm = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (!s.mode) begin
               next_s.fsm = ST_IDLE;
            end else if (zc) begin
               next_s.fsm = ST_ACC;
               next_s.sum = '0;
               next_s.hc  = '0;
            end
         end
         ST_ACC: begin
            if (!s.mode) begin
               next_s.fsm = ST_IDLE;
            end else begin
               if (upd) begin
                  // Wraps at 40 bits like the hardware counter
                  next_s.sum = s.sum + scaled_ext;
               end
               if (zc) begin
                  // A count of zero behaves as one half cycle
                  if (hc_next >= {1'b0, s.hcc}) begin
                     next_s.total = next_s.sum;
                     next_s.sum   = '0;
                     next_s.hc    = '0;
                     next_s.done  = 1'b1;
                  end else begin
                     next_s.hc = hc_next[HCC_W-1:0];
                  end
               end
            end
         end
         default: begin
            next_s.fsm = ST_IDLE;
         end
      endcase

      next_s.irq_n = !(next_s.done && next_s.ien);
   end

   // ============================================================
   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         s         <= '0;
         s.fsm     <= ST_IDLE;
         s.num     <= PULSE_NUM_RST;
         s.den     <= PULSE_DEN_RST;
         s.gain    <= GAIN_RST;
         s.hcc     <= HCC_RST;
         s.irq_n   <= 1'b1;
         s.awready <= 1'b1;
         s.wready  <= 1'b1;
         s.arready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ============================================================
   // Outputs
   assign irq_n            = s.irq_n;
   assign axil_rsp.awready = s.awready;
   assign axil_rsp.wready  = s.wready;
   assign axil_rsp.bvalid  = s.bvalid;
   assign axil_rsp.bresp   = s.bresp;
   assign axil_rsp.arready = s.arready;
   assign axil_rsp.rvalid  = s.rvalid;
   assign axil_rsp.rdata   = s.rdata;
   assign axil_rsp.rresp   = s.rresp;
endmodule : lce_accumulator
`default_nettype wire

//--- design/lce_pkg.sv
// Shared constants and bus carriers for the line-cycle energy accumulator
`default_nettype none
package lce_pkg;
   // ============================================================
   // Widths
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int HCC_W      = 14;
   localparam int ENERGY_W   = 40;
   localparam int PWR_W      = 24;
   localparam int SCALED_W   = 25;
   localparam int ETF_W      = 24;
   localparam int DIV_W      = 12;
   localparam int GAIN_W     = 12;
   localparam int GAIN_SHIFT = 12;
   localparam int UPD_DIV    = 4;

   // ============================================================
   // Register byte offsets
   localparam logic [7:0] OFF_MODE      = 8'h00;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h04;
   localparam logic [7:0] OFF_IRQ_EN    = 8'h08;
   localparam logic [7:0] OFF_PULSE_NUM = 8'h0C;
   localparam logic [7:0] OFF_PULSE_DEN = 8'h10;
   localparam logic [7:0] OFF_CYCLE     = 8'h14;
   localparam logic [7:0] OFF_CYC_HI    = 8'h18;
   localparam logic [7:0] OFF_GAIN      = 8'h1C;
   localparam logic [7:0] OFF_RUN_LO    = 8'h20;
   localparam logic [7:0] OFF_RUN_HI    = 8'h24;
   localparam logic [7:0] OFF_HCC_RD    = 8'h28;

   // ============================================================
   // Field positions
   localparam int MODE_CYC_BIT = 7;
   localparam int IRQ_DONE_BIT = 2;

   // ============================================================
   // Reset values
   localparam logic [11:0] PULSE_DEN_RST = 12'h03F;
   localparam logic [11:0] PULSE_NUM_RST = 12'h000;
   localparam logic [11:0] GAIN_RST      = 12'h000;
   localparam logic [13:0] HCC_RST       = 14'h0000;

   // ============================================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } lce_axil_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } lce_axil_rsp_t;
endpackage : lce_pkg
`default_nettype wire

//--- design/lce_zero_cross.sv
// Voltage-channel zero-crossing detector and line-following output
`default_nettype none
module lce_zero_cross
   import lce_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Voltage sign from the filter chain
   input  wire logic volt_sign,
   // Crossing event and line-following level
   output logic      zc_pulse,
   output logic      zero_cross_out
);
   typedef struct packed {
      logic prev;
      logic pulse;
      logic level;
   } lce_zc_state_t;

   lce_zc_state_t s;
   lce_zc_state_t next_s;

   // ============================================================
   // Edge detect
   always_comb begin
      next_s       = s;
      next_s.prev  = volt_sign;
      next_s.pulse = volt_sign ^ s.prev;
      next_s.level = ~volt_sign;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign zc_pulse       = s.pulse;
   assign zero_cross_out = s.level;
endmodule : lce_zero_cross
`default_nettype wire

//--- design/lce_pulse_gen.sv
// Energy-to-frequency pulse generator with rational rate scaling
`default_nettype none
module lce_pulse_gen
   import lce_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       srst,
   // Power samples
   input  wire logic                       upd,
   input  wire logic signed [SCALED_W-1:0] power,
   // Rate dividers
   input  wire logic        [DIV_W-1:0]    pulse_num,
   input  wire logic        [DIV_W-1:0]    pulse_den,
   // Pulse output
   output logic                            pulse
);
   typedef struct packed {
      logic [ETF_W-1:0] acc;
      logic [DIV_W:0]   frac;
      logic             pulse;
   } lce_pg_state_t;

   lce_pg_state_t      s;
   lce_pg_state_t      next_s;
   logic [ETF_W-1:0]   acc_sum;
   logic [DIV_W+1:0]   frac_sum;
   logic [DIV_W+1:0]   den_p1;

   assign acc_sum  = s.acc + power[ETF_W-1:0];
   assign frac_sum = {1'b0, s.frac} + {2'h0, pulse_num} + 14'h0001;
   assign den_p1   = {2'h0, pulse_den} + 14'h0001;

   // ============================================================
   // Accumulate and divide
   always_comb begin
      next_s       = s;
      next_s.pulse = 1'b0;
      if (upd) begin
         next_s.acc = acc_sum;
         // MSB rising marks one undivided output event
         if (!s.acc[ETF_W-1] && acc_sum[ETF_W-1]) begin
            if (frac_sum >= den_p1) begin
               next_s.frac  = (DIV_W+1)'(frac_sum - den_p1);
               next_s.pulse = 1'b1;
            end else begin
               next_s.frac = frac_sum[DIV_W:0];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pulse = s.pulse;
endmodule : lce_pulse_gen
`default_nettype wire

//--- testbench/lce_accumulator_monitor.sv
// Port-level checker for the line-cycle energy accumulator
`default_nettype none
module lce_accumulator_monitor
   import lce_pkg::*;
(
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    srst,
   // Register bus
   input wire lce_axil_req_t           axil_req,
   input wire lce_axil_rsp_t           axil_rsp,
   // Signal chain and pins
   input wire logic signed [PWR_W-1:0] active_power,
   input wire logic                    volt_sign,
   input wire logic                    irq_n,
   input wire logic                    energy_pulse_out,
   input wire logic                    zero_cross_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // ========
   // Shadow of bus traffic
   logic [1:0] age;
   logic [7:0] aw_q;
   logic [7:0] ar_q;
   logic [1:0] w_q;
   logic       en_q;
   logic       den_wr;

   always_ff @(posedge clk) begin
      if (srst) begin
         age    <= 2'h0;
         en_q   <= 1'b0;
         den_wr <= 1'b0;
      end else begin
         if (age != 2'h3) age <= age + 2'h1;
         if (axil_req.awvalid && axil_rsp.awready) aw_q <= axil_req.awaddr;
         if (axil_req.arvalid && axil_rsp.arready) ar_q <= axil_req.araddr;
         if (axil_req.wvalid && axil_rsp.wready) w_q <= {axil_req.wstrb[0], axil_req.wdata[2]};
         // Enable shadow lags the register by one cycle, covered by the bvalid term below
         if (axil_rsp.bvalid && axil_req.bready) begin
            if (aw_q == OFF_IRQ_EN && w_q[1]) en_q <= w_q[0];
            if (aw_q == OFF_PULSE_DEN) den_wr <= 1'b1;
         end
      end
   end

   // ========
   // Assertions
   AST_ZX_FOLLOW: assert property (age == 2'h3 |-> zero_cross_out == !$past(volt_sign))
      else $error("zero-cross output does not follow the voltage sign");
   AST_PULSE_GAP: assert property (energy_pulse_out |=> !energy_pulse_out [*3])
      else $error("energy pulses closer than one update period");
   AST_IRQ_EN: assert property (!irq_n |-> en_q || axil_rsp.bvalid)
      else $error("interrupt asserted with its enable clear");
   AST_DEN_RST: assert property (axil_rsp.rvalid && ar_q == OFF_PULSE_DEN && !den_wr
      |-> axil_rsp.rdata[11:0] == PULSE_DEN_RST)
      else $error("denominator reset value wrong");
   AST_HCC_W: assert property (axil_rsp.rvalid && ar_q == OFF_HCC_RD
      |-> axil_rsp.rdata[31:14] == 18'h0)
      else $error("half-cycle count wider than its field");
   AST_CYC_SIGN: assert property (axil_rsp.rvalid && ar_q == OFF_CYC_HI
      |-> axil_rsp.rdata[31:8] == {24{axil_rsp.rdata[7]}})
      else $error("cycle total high word not sign extended");
   AST_RUN_SIGN: assert property (axil_rsp.rvalid && ar_q == OFF_RUN_HI
      |-> axil_rsp.rdata[31:8] == {24{axil_rsp.rdata[7]}})
      else $error("running total high word not sign extended");
   AST_RD_LAT: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
      else $error("read answer late");
   AST_R_HOLD: assert property (axil_rsp.rvalid && !axil_req.rready
      |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
      else $error("read data dropped before rready");
   AST_B_ORDER: assert property ($rose(axil_rsp.bvalid)
      |-> $past(!axil_rsp.awready && !axil_rsp.wready))
      else $error("write answer before address and data taken");
endmodule : lce_accumulator_monitor

bind lce_accumulator lce_accumulator_monitor u_mon (
   .clk(clk), .srst(srst), .axil_req(axil_req), .axil_rsp(axil_rsp),
   .active_power(active_power), .volt_sign(volt_sign), .irq_n(irq_n),
   .energy_pulse_out(energy_pulse_out), .zero_cross_out(zero_cross_out)
);
`default_nettype wire

//--- testbench/lce_host_model.sv
// Host-side model that tallies energy pulses and zero-cross edges
`default_nettype none
module lce_host_model
   import lce_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Device pins
   input  wire logic        energy_pulse_out,
   input  wire logic        zero_cross_out,
   // Tallies
   output logic      [31:0] pulse_count,
   output logic      [31:0] zx_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic zx_q;

   // Each pulse is a fixed energy quantum, so a plain tally is the meter total
   always_ff @(posedge clk) begin
      if (srst) begin
         pulse_count <= 32'h0000_0000;
         zx_edges    <= 32'h0000_0000;
      end else begin
         if (energy_pulse_out) pulse_count <= pulse_count + 32'h0000_0001;
         if (zero_cross_out != zx_q) zx_edges <= zx_edges + 32'h0000_0001;
      end
      zx_q <= zero_cross_out;
   end
endmodule : lce_host_model
`default_nettype wire

//--- testbench/lce_accumulator_test.sv
// Self-checking bench for the line-cycle energy accumulator
`default_nettype none
module lce_accumulator_test
   import lce_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 40;
   typedef struct packed {
      logic [11:0] num;
      logic [11:0] den;
      logic [11:0] gain;
      logic [7:0]  pulses;
   } lce_row_t;
   lce_row_t rows [5] = '{
      '{12'h000, 12'h000, 12'h000, 8'h40}, '{12'h000, 12'h003, 12'h000, 8'h10},
      '{12'h002, 12'h007, 12'h000, 8'h18}, '{12'h000, 12'h000, 12'h400, 8'h50},
      '{12'h000, 12'h000, 12'hC00, 8'h30}};
   logic signed [PWR_W-1:0] pw [2] = '{24'sh7F_FFFF, 24'sh80_0000};
   logic                    clk;
   logic                    srst;
   lce_axil_req_t           req;
   lce_axil_rsp_t           rsp;
   logic signed [PWR_W-1:0] power;
   logic                    volt_sign;
   logic                    zx_run;
   logic                    irq_n;
   logic                    pulse;
   logic                    zx_out;
   logic        [31:0]      pcount;
   logic        [31:0]      zcount;
   logic        [31:0]      base;
   logic        [31:0]      seen;
   longint                  e;
   int                      errors = 0;
   int                      cmp_count = 0;
   int                      zx_cnt = 0;

   lce_accumulator u_dut (
      .clk(clk), .srst(srst), .axil_req(req), .axil_rsp(rsp), .active_power(power),
      .volt_sign(volt_sign), .irq_n(irq_n), .energy_pulse_out(pulse), .zero_cross_out(zx_out));
   lce_host_model u_host (
      .clk(clk), .srst(srst), .energy_pulse_out(pulse), .zero_cross_out(zx_out),
      .pulse_count(pcount), .zx_edges(zcount));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Voltage line with a fixed half period, so every period holds a whole number of updates
   always @(posedge clk) begin
      if (zx_run) begin
         zx_cnt <= (zx_cnt == HALF - 1) ? 0 : zx_cnt + 1;
         if (zx_cnt == HALF - 1) volt_sign <= ~volt_sign;
      end
   end

   // ========
   // Tasks
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.bready  <= 1'b1;
      forever begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      req.bready <= 1'b0;
      check("bresp", {30'h0, rsp.bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      forever begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      req.rready <= 1'b0;
      check($sformatf("read %h", a), rsp.rdata, exp);
      check("rresp", {30'h0, rsp.rresp}, {30'h0, er});
   endtask : rd

   task automatic wait_done;
      while (irq_n !== 1'b0) @(posedge clk);
      rd(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
      check("irq_n", {31'h0, irq_n}, 32'h0000_0001);
   endtask : wait_done

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      final_report();
   end

   // ========
   // Stimulus
   initial begin
      req = '0;
      req.wstrb = 4'hF;
      power = '0;
      volt_sign = 1'b0;
      zx_run = 1'b1;
      srst = 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rd(OFF_PULSE_DEN, 32'h0000_003F, RESP_OKAY);
      rd(OFF_PULSE_NUM, 32'h0000_0000, RESP_OKAY);
      rd(OFF_RUN_LO, 32'h0000_0000, RESP_OKAY);
      power <= 24'shFF_FF00;
      repeat (200) @(posedge clk);
      rd(OFF_RUN_HI, 32'hFFFF_FFFF, RESP_OKAY);
      foreach (rows[i]) begin
         wr(OFF_PULSE_NUM, {20'h0, rows[i].num}, RESP_OKAY);
         wr(OFF_PULSE_DEN, {20'h0, rows[i].den}, RESP_OKAY);
         wr(OFF_GAIN, {20'h0, rows[i].gain}, RESP_OKAY);
         power <= 24'sh10_0000;
         repeat (64) @(posedge clk);
         base = pcount;
         repeat (4096) @(posedge clk);
         seen = pcount - base;
         check("pulses", (seen + 2 - rows[i].pulses <= 4) ? rows[i].pulses : seen, rows[i].pulses);
      end
      // Awkward cases: field width, unmapped place, line-cycle periods
      wr(OFF_CYCLE, 32'h0000_FFFF, RESP_OKAY);
      rd(OFF_HCC_RD, 32'h0000_3FFF, RESP_OKAY);
      wr(8'h30, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(8'h30, 32'h0000_0000, RESP_SLVERR);
      rd(OFF_GAIN, 32'h0000_0C00, RESP_OKAY);
      wr(OFF_GAIN, 32'h0000_0000, RESP_OKAY);
      wr(OFF_CYCLE, 32'h0000_0003, RESP_OKAY);
      wr(OFF_IRQ_EN, 32'h0000_0004, RESP_OKAY);
      power <= pw[0];
      wr(OFF_MODE, 32'h0000_0080, RESP_OKAY);
      rd(OFF_MODE, 32'h0000_0080, RESP_OKAY);
      rd(OFF_IRQ_EN, 32'h0000_0004, RESP_OKAY);
      foreach (pw[j]) begin
         power <= pw[j];
         wait_done();
         wait_done();
         e = longint'(pw[j]) * (3 * HALF / 4);
         rd(OFF_CYCLE, e[31:0], RESP_OKAY);
         rd(OFF_CYC_HI, {{24{e[39]}}, e[39:32]}, RESP_OKAY);
      end
      zx_run <= 1'b0;
      repeat (8) @(posedge clk);
      wr(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
      repeat (400) @(posedge clk);
      check("irq_n", {31'h0, irq_n}, 32'h0000_0001);
      zx_run <= 1'b1;
      base = zcount;
      repeat (400) @(posedge clk);
      // Stop the line again so the window holds exactly ten toggles, whatever the phase
      zx_run <= 1'b0;
      repeat (4) @(posedge clk);
      check("zx_edges", zcount - base, 32'h0000_000A);
      zx_run <= 1'b1;
      wr(OFF_MODE, 32'h0000_0000, RESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
      repeat (400) @(posedge clk);
      check("irq_n", {31'h0, irq_n}, 32'h0000_0001);
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rd(OFF_PULSE_DEN, 32'h0000_003F, RESP_OKAY);
      final_report();
   end
endmodule : lce_accumulator_test
`default_nettype wire
